// File: wdrc_map.vh
/*
 * Register map, field positions, reset values and counts for the
 * watchdog and reset-cause block.
 * Assumes: included by bare name from every design file that needs it.
 */
`ifndef WDRC_MAP_VH
`define WDRC_MAP_VH

// register bus
`define WDRC_ADDR_W 4
`define WDRC_DATA_W 8
`define WDRC_ZERO8 8'h00

// register offsets
`define WDRC_OFF_CAUSE 4'h0
`define WDRC_OFF_CTRL 4'h1
`define WDRC_OFF_IRQ_STAT 4'h2
`define WDRC_OFF_IRQ_MASK 4'h3

// reset_cause_status fields
`define WDRC_CAUSE_W 5
`define WDRC_CAUSE_POR 0
`define WDRC_CAUSE_PIN 1
`define WDRC_CAUSE_BOR 2
`define WDRC_CAUSE_DOG 3
`define WDRC_CAUSE_SCAN 4
`define WDRC_CAUSE_RST 5'h01
`define WDRC_CAUSE_NONE 5'h00

// watchdog_control fields
`define WDRC_CTRL_UNLOCK 4
`define WDRC_CTRL_EN 3
`define WDRC_CTRL_SEL_HI 2
`define WDRC_CTRL_SEL_LO 0
`define WDRC_SEL_W 3
`define WDRC_SEL_RST 3'h0

// turn-off unlock window in system clock cycles
`define WDRC_UNLOCK_W 3
`define WDRC_UNLOCK_CYCLES 3'h4
`define WDRC_UNLOCK_NONE 3'h0
`define WDRC_UNLOCK_STEP 3'h1

// watchdog counter
`define WDRC_CNT_W 21
`define WDRC_CNT_ZERO 21'h000000
`define WDRC_CNT_ONE 21'h000001
`define WDRC_BASE_CYCLES 32'h00004000

// interrupt status and mask fields
`define WDRC_IRQ_W 4
`define WDRC_IRQ_DOG 0
`define WDRC_IRQ_PIN 1
`define WDRC_IRQ_BOR 2
`define WDRC_IRQ_SCAN 3
`define WDRC_IRQ_NONE 4'h0

// synchronised pin inputs
`define WDRC_SYNC_W 4
`define WDRC_SYNC_OSC 0
`define WDRC_SYNC_PIN 1
`define WDRC_SYNC_BOR 2
`define WDRC_SYNC_SCAN 3
`define WDRC_SYNC_RST 4'h0

`endif

// File: wdrc_sync.v
/*
 * Two-flop synchroniser, one chain per input bit.
 * Assumes: inputs are asynchronous pins; only the second flop is read.
 */
`include "wdrc_map.vh"

module wdrc_sync #(
    parameter WIDTH = `WDRC_SYNC_W
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // asynchronous inputs and their synchronised copies
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_q;
            reg stable_q;
            // first flop feeds only the second one
            always @(posedge clk) begin
                if (!reset_n) begin
                    meta_q <= 1'b0;
                    stable_q <= 1'b0;
                end else begin
                    meta_q <= async_in[i];
                    stable_q <= meta_q;
                end
            end
            assign sync_out[i] = stable_q;
        end
    endgenerate

endmodule // wdrc_sync

// File: wdrc_wdog.v
/*
 * Watchdog time-out counter, advanced by one tick per watchdog
 * oscillator cycle; time-out is base length shifted by the select code.
 * Assumes: tick is a one-cycle pulse on clk; clear has priority.
 */
`include "wdrc_map.vh"

module wdrc_wdog #(
    parameter [31:0] BASE_CYCLES = `WDRC_BASE_CYCLES
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // control
    input wire tick,
    input wire clear,
    input wire enable,
    input wire [`WDRC_SEL_W-1:0] sel,
    // one-cycle time-out pulse
    output reg timeout_q
);

    reg [`WDRC_CNT_W-1:0] cnt_q;
    reg [`WDRC_CNT_W-1:0] cnt_d;
    reg timeout_d;
    wire [31:0] limit_wide;
    wire [`WDRC_CNT_W-1:0] limit;

    // last count value of the period selected by the prescaler
    assign limit_wide = (BASE_CYCLES << sel) - 32'h00000001; // RULE12
    assign limit = limit_wide[`WDRC_CNT_W-1:0];

    // count only while enabled, so the select matters only then
    always @* begin
        cnt_d = cnt_q;
        timeout_d = 1'b0;
        if (clear || !enable) begin
            cnt_d = `WDRC_CNT_ZERO; // RULE15 RULE13
        end else if (tick) begin
            if (cnt_q == limit) begin
                cnt_d = `WDRC_CNT_ZERO;
                timeout_d = 1'b1; // RULE14
            end else begin
                cnt_d = cnt_q + `WDRC_CNT_ONE;
            end
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            cnt_q <= `WDRC_CNT_ZERO;
            timeout_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            timeout_q <= timeout_d; // RULE16
        end
    end

endmodule // wdrc_wdog

// File: wdrc_top.v
/*
 * Watchdog control and reset-cause recording, with register port,
 * sticky interrupt status and one level interrupt.
 * Register map, one byte each: 0 holds the reset cause flags in
 * bits 4 to 0; 1 the watchdog control, unlock in bit 4, enable in
 * bit 3, time-out select in bits 2 to 0; 2 the interrupt status,
 * write one to clear, dog in bit 0, pin, brown-out and scan in bits
 * 1 to 3; 3 the interrupt mask, same layout as the status.
 * Assumes: reset_n is the power-on reset; other reset sources arrive
 * as asynchronous active-high levels held for at least three clocks;
 * the watchdog oscillator arrives as a slow square wave on a pin with
 * each level held for at least three clocks, or ticks are lost;
 * restart comes from the core on clk.
 */
// Behaviour
// RULE1: scan-port reset sets bit 4; zero write clears
// RULE2: watchdog reset sets bit 3; zero write clears
// RULE3: brown-out reset sets bit 2; zero write clears
// RULE4: pin reset sets bit 1; zero write clears
// RULE5: power-on sets bit 0; only zero write clears
// RULE6: software reads then clears cause flags early
// RULE7: control bits 7 to 5 read zero
// RULE8: unlock bit self-clears four cycles after set
// RULE9: enable sets freely; clears only while unlocked
// RULE10: software writes unlock and enable together first
// RULE11: software writes enable zero within four cycles
// RULE12: select code picks 16K shifted time-out
// RULE13: select governs time-out only while enabled
// RULE14: restart clears counter; expiry resets the chip
// RULE15: counter cleared when disabled or chip reset
// RULE16: time-out gives one-cycle reset pulse
// RULE17: counter stepped by separate watchdog oscillator
// RULE18: writing one to a cause flag changes nothing
`include "wdrc_map.vh"

module wdrc_top #(
    parameter [31:0] TIMEOUT_BASE = `WDRC_BASE_CYCLES
) (
    // clock and power-on reset
    input wire clk,
    input wire reset_n,
    // register port
    input wire [`WDRC_ADDR_W-1:0] addr,
    input wire [`WDRC_DATA_W-1:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [`WDRC_DATA_W-1:0] rdata_q,
    // core restart strobe
    input wire restart,
    // asynchronous pins
    input wire wdt_osc,
    input wire pin_reset_in,
    input wire brownout_reset_in,
    input wire scan_reset_in,
    // reset outputs
    output wire wdt_reset_pulse,
    output reg chip_reset_q,
    // status and interrupt
    output wire watchdog_active,
    output reg irq_q
);

    // synchronised levels, events and decoded strobes
    wire [`WDRC_SYNC_W-1:0] sync_lvl;
    wire osc_s;
    wire pin_s;
    wire bor_s;
    wire scan_s;
    wire osc_tick;
    wire dog_pulse;
    wire chip_rst;
    wire wr_cause;
    wire wr_ctrl;
    wire wr_stat;
    wire wr_mask;
    wire unlocked;
    wire [`WDRC_IRQ_W-1:0] irq_evt;

    // register state and next values
    reg osc_prev_q;
    reg [`WDRC_SYNC_W-1:0] src_prev_q;
    reg [`WDRC_CAUSE_W-1:0] cause_q;
    reg [`WDRC_CAUSE_W-1:0] cause_d;
    reg en_q;
    reg en_d;
    reg [`WDRC_SEL_W-1:0] sel_q;
    reg [`WDRC_SEL_W-1:0] sel_d;
    reg [`WDRC_UNLOCK_W-1:0] unlock_cnt_q;
    reg [`WDRC_UNLOCK_W-1:0] unlock_cnt_d;
    reg [`WDRC_IRQ_W-1:0] stat_q;
    reg [`WDRC_IRQ_W-1:0] stat_d;
    reg [`WDRC_IRQ_W-1:0] mask_q;
    reg [`WDRC_IRQ_W-1:0] mask_d;
    reg [`WDRC_DATA_W-1:0] rdata_d;

    // every pin passes two flops before use
    wdrc_sync #(
        .WIDTH(`WDRC_SYNC_W)
    ) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async_in({scan_reset_in, brownout_reset_in, pin_reset_in, wdt_osc}),
        .sync_out(sync_lvl)
    );

    assign osc_s = sync_lvl[`WDRC_SYNC_OSC];
    assign pin_s = sync_lvl[`WDRC_SYNC_PIN];
    assign bor_s = sync_lvl[`WDRC_SYNC_BOR];
    assign scan_s = sync_lvl[`WDRC_SYNC_SCAN];

    // one tick per oscillator rising edge; osc must stay well below clk/4
    // a missed edge only stretches the time-out, never shortens it
    assign osc_tick = osc_s & ~osc_prev_q; // RULE17

    // watchdog counter, restarted by the core, disable or chip reset
    wdrc_wdog #(
        .BASE_CYCLES(TIMEOUT_BASE)
    ) u_wdog (
        .clk(clk),
        .reset_n(reset_n),
        .tick(osc_tick),
        .clear(restart | chip_rst), // RULE14 RULE15
        .enable(en_q),
        .sel(sel_q),
        .timeout_q(dog_pulse)
    );

    // any source puts the chip in reset; the dog pulse is one cycle
    assign chip_rst = pin_s | bor_s | scan_s | dog_pulse;
    assign wdt_reset_pulse = dog_pulse; // RULE16
    assign watchdog_active = en_q;

    // register write decode
    assign wr_cause = wr_en && (addr == `WDRC_OFF_CAUSE);
    assign wr_ctrl = wr_en && (addr == `WDRC_OFF_CTRL);
    assign wr_stat = wr_en && (addr == `WDRC_OFF_IRQ_STAT);
    assign wr_mask = wr_en && (addr == `WDRC_OFF_IRQ_MASK);

    // unlock bit reads one while the window counter runs
    assign unlocked = (unlock_cnt_q != `WDRC_UNLOCK_NONE); // RULE8

    // cause flags: write keeps ones and clears zeros, then sets win
    // a source still high keeps its flag set whatever is written
    always @* begin
        cause_d = cause_q;
        if (wr_cause) begin
            cause_d = cause_q & wdata[`WDRC_CAUSE_W-1:0]; // RULE18
        end
        if (scan_s) begin
            cause_d[`WDRC_CAUSE_SCAN] = 1'b1; // RULE1
        end
        if (dog_pulse) begin
            cause_d[`WDRC_CAUSE_DOG] = 1'b1; // RULE2
        end
        if (bor_s) begin
            cause_d[`WDRC_CAUSE_BOR] = 1'b1; // RULE3
        end
        if (pin_s) begin
            cause_d[`WDRC_CAUSE_PIN] = 1'b1; // RULE4
        end
    end

    // control: chip reset restores defaults, beating any write
    // a write lost to a chip reset is not retried; software redoes it
    always @* begin
        en_d = en_q;
        sel_d = sel_q;
        unlock_cnt_d = unlock_cnt_q;
        if (unlocked) begin
            unlock_cnt_d = unlock_cnt_q - `WDRC_UNLOCK_STEP; // RULE8
        end
        if (chip_rst) begin
            en_d = 1'b0;
            sel_d = `WDRC_SEL_RST;
            unlock_cnt_d = `WDRC_UNLOCK_NONE;
        end else if (wr_ctrl) begin
            sel_d = wdata[`WDRC_CTRL_SEL_HI:`WDRC_CTRL_SEL_LO]; // RULE12
            if (wdata[`WDRC_CTRL_EN]) begin
                en_d = 1'b1; // RULE9
            end else if (unlocked) begin
                en_d = 1'b0; // RULE9 RULE11
            end
            if (wdata[`WDRC_CTRL_UNLOCK]) begin
                unlock_cnt_d = `WDRC_UNLOCK_CYCLES; // RULE8 RULE10
            end
        end
    end

    // the dog pulse is an event by itself
    assign irq_evt[`WDRC_IRQ_DOG] = dog_pulse;

    // each reset source rising is an event; pin, brown-out and scan
    // sit at the same bit positions in the sync and status words
    genvar src_i;
    generate
        for (src_i = `WDRC_SYNC_PIN; src_i <= `WDRC_SYNC_SCAN; src_i = src_i + 1) begin : g_evt
            assign irq_evt[src_i] = sync_lvl[src_i] & ~src_prev_q[src_i];
        end
    endgenerate

    // sticky status, write one to clear, a new event wins
    always @* begin
        stat_d = stat_q;
        if (wr_stat) begin
            stat_d = stat_q & ~wdata[`WDRC_IRQ_W-1:0];
        end
        stat_d = stat_d | irq_evt;
    end

    // mask is plain read-write
    always @* begin
        mask_d = mask_q;
        if (wr_mask) begin
            mask_d = wdata[`WDRC_IRQ_W-1:0];
        end
    end

    // read mux; data valid only in the cycle after the strobe
    // unmapped offsets and idle cycles read zero
    always @* begin
        rdata_d = `WDRC_ZERO8;
        if (rd_en) begin
            case (addr)
                `WDRC_OFF_CAUSE: begin
                    rdata_d[`WDRC_CAUSE_W-1:0] = cause_q;
                end
                `WDRC_OFF_CTRL: begin
                    // bits 7 to 5 stay at zero from the default above
                    rdata_d[`WDRC_CTRL_UNLOCK] = unlocked; // RULE7
                    rdata_d[`WDRC_CTRL_EN] = en_q;
                    rdata_d[`WDRC_CTRL_SEL_HI:`WDRC_CTRL_SEL_LO] = sel_q;
                end
                `WDRC_OFF_IRQ_STAT: begin
                    rdata_d[`WDRC_IRQ_W-1:0] = stat_q;
                end
                `WDRC_OFF_IRQ_MASK: begin
                    rdata_d[`WDRC_IRQ_W-1:0] = mask_q;
                end
                default: begin
                    rdata_d = `WDRC_ZERO8;
                end
            endcase
        end
    end

    // cause flags; power-on alone records bit 0 and clears the rest
    always @(posedge clk) begin
        if (!reset_n) begin
            cause_q <= `WDRC_CAUSE_RST; // RULE5
        end else begin
            cause_q <= cause_d;
        end
    end

    // control fields and the unlock window counter
    always @(posedge clk) begin
        if (!reset_n) begin
            en_q <= 1'b0;
            sel_q <= `WDRC_SEL_RST;
            unlock_cnt_q <= `WDRC_UNLOCK_NONE;
        end else begin
            en_q <= en_d;
            sel_q <= sel_d;
            unlock_cnt_q <= unlock_cnt_d;
        end
    end

    // interrupt status and mask
    always @(posedge clk) begin
        if (!reset_n) begin
            stat_q <= `WDRC_IRQ_NONE;
            mask_q <= `WDRC_IRQ_NONE;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
        end
    end

    // previous levels for edge detection; reset to the idle pin level
    // so that no false edge follows reset
    always @(posedge clk) begin
        if (!reset_n) begin
            osc_prev_q <= 1'b0;
            src_prev_q <= `WDRC_SYNC_RST;
        end else begin
            osc_prev_q <= osc_s;
            src_prev_q <= sync_lvl;
        end
    end

    // outputs from flops; the interrupt uses next-state status and mask
    // so it follows the status register with no extra cycle of lag
    always @(posedge clk) begin
        if (!reset_n) begin
            rdata_q <= `WDRC_ZERO8;
            chip_reset_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            chip_reset_q <= chip_rst;
            irq_q <= |(stat_d & mask_d);
        end
    end

endmodule // wdrc_top

// File: wdrc_top_chk.sv
/* port checker for wdrc_top: watchdog pulse, enable lock, unlock window.
   assumes the map header and the bind at the foot of this file. */
`include "wdrc_map.vh"
module wdrc_top_chk (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [`WDRC_ADDR_W-1:0] addr,
    input wire logic [`WDRC_DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [`WDRC_DATA_W-1:0] rdata_q,
    // core and pins
    input wire logic restart,
    input wire logic wdt_osc,
    input wire logic pin_reset_in,
    input wire logic brownout_reset_in,
    input wire logic scan_reset_in,
    // outputs
    input wire logic wdt_reset_pulse,
    input wire logic chip_reset_q,
    input wire logic watchdog_active,
    input wire logic irq_q
);
    logic [2:0] win_q;
    logic [2:0] win_d;
    logic [1:0] src_sh_q;
    logic src_hit;
    logic ctl_wr;
    logic ctl_rd;
    // shadow of the unlock window, four cycles after an unlocking write
    assign ctl_wr = wr_en && addr == `WDRC_OFF_CTRL;
    assign ctl_rd = rd_en && addr == `WDRC_OFF_CTRL;
    // the design's chip reset: a source two clocks late, or the dog pulse
    assign src_hit = src_sh_q[1] || wdt_reset_pulse;
    always_comb begin
        win_d = (win_q == 3'h0) ? 3'h0 : win_q - 3'h1;
        if (ctl_wr && wdata[`WDRC_CTRL_UNLOCK])
            win_d = 3'h4;
        if (src_hit)
            win_d = 3'h0;
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            win_q <= 3'h0;
            src_sh_q <= 2'h0;
        end else begin
            win_q <= win_d;
            src_sh_q <= {src_sh_q[0], pin_reset_in | brownout_reset_in | scan_reset_in};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // the two writes of the turn-off sequence
    sequence s_unlock; ctl_wr && wdata[4:3] == 2'h3; endsequence
    sequence s_off; ctl_wr && wdata[4:3] == 2'h0; endsequence
    pulse_one_cyc_a: assert property (wdt_reset_pulse |=> !wdt_reset_pulse)
        else $error("dog pulse longer than one cycle");
    chip_follow_a: assert property (wdt_reset_pulse |=> chip_reset_q)
        else $error("dog pulse without chip reset");
    chip_clr_en_a: assert property (chip_reset_q |-> !watchdog_active)
        else $error("enable kept through chip reset");
    idle_no_pulse_a: assert property (!watchdog_active [*2] |-> !wdt_reset_pulse)
        else $error("pulse while disabled");
    ctrl_resv_a: assert property (ctl_rd |=> rdata_q[7:5] == 3'h0)
        else $error("reserved control bits not zero");
    en_set_a: assert property (
        ctl_wr && wdata[3] && !src_hit |=> watchdog_active)
        else $error("enable write ignored");
    off_locked_a: assert property (
        s_off ##0 (win_q == 3'h0 && watchdog_active && !src_hit) |=> watchdog_active)
        else $error("disabled without unlock");
    off_seq_a: assert property (s_unlock ##[1:4] s_off |=> !watchdog_active)
        else $error("turn-off sequence failed");
    unlock_open_a: assert property (ctl_rd && win_q != 3'h0 |=> rdata_q[4])
        else $error("unlock bit low inside window");
    unlock_shut_a: assert property (ctl_rd && win_q == 3'h0 |=> !rdata_q[4])
        else $error("unlock bit high after window");
endmodule // wdrc_top_chk

bind wdrc_top wdrc_top_chk chk_u (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .restart(restart),
    .wdt_osc(wdt_osc), .pin_reset_in(pin_reset_in), .brownout_reset_in(brownout_reset_in),
    .scan_reset_in(scan_reset_in), .wdt_reset_pulse(wdt_reset_pulse),
    .chip_reset_q(chip_reset_q), .watchdog_active(watchdog_active), .irq_q(irq_q));

// File: watchdog_and_reset_cause_test.sv
/* self-checking bench for wdrc_top.
   assumes design files and checker are compiled before it. */
`include "wdrc_map.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
module watchdog_and_reset_cause_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BASE = 4; // short time-out keeps the run brief
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic restart = 1'b0;
    logic wdt_osc = 1'b0;
    logic [2:0] src = 3'h0; // pin, brown-out, scan
    logic [7:0] rdata_q;
    logic wdt_reset_pulse, chip_reset_q, watchdog_active, irq_q;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_pulse = 0;
    always #2.5 clk = ~clk;
    // pulse is one cycle wide, so count it on every edge
    always @(posedge clk) if (wdt_reset_pulse === 1'b1) n_pulse++;
    wdrc_top #(.TIMEOUT_BASE(BASE)) dut_u (.clk(clk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .restart(restart),
        .wdt_osc(wdt_osc), .pin_reset_in(src[0]), .brownout_reset_in(src[1]),
        .scan_reset_in(src[2]), .wdt_reset_pulse(wdt_reset_pulse),
        .chip_reset_q(chip_reset_q), .watchdog_active(watchdog_active), .irq_q(irq_q));
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        `CHK("rdata", e, rdata_q)
    endtask
    // each phase spans four clocks so the synchroniser sees every edge
    task automatic ticks(input int n);
        repeat (n) begin
            wdt_osc <= 1'b1;
            repeat (4) @(posedge clk);
            wdt_osc <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic t_reset;
        rd(`WDRC_OFF_CAUSE, 8'h01);
        rd(`WDRC_OFF_CTRL, 8'h00);
        rd(`WDRC_OFF_IRQ_MASK, 8'h00);
        rd(4'hF, 8'h00);
        `CHK("irq", 1'b0, irq_q)
        $display("test reset done");
    endtask
    task automatic t_cause;
        logic [7:0] e;
        logic [7:0] st;
        e = 8'h01;
        st = 8'h00;
        for (int i = 0; i < 3; i++) begin
            src <= 3'h1 << i;
            repeat (8) @(posedge clk);
            src <= 3'h0;
            repeat (8) @(posedge clk);
            e = e | (i == 0 ? 8'h02 : i == 1 ? 8'h04 : 8'h10);
            st = st | (8'h02 << i);
            rd(`WDRC_OFF_CAUSE, e);
            rd(`WDRC_OFF_IRQ_STAT, st);
        end
        `CHK("irq", 1'b0, irq_q)
        wr(`WDRC_OFF_IRQ_MASK, 8'h02);
        @(posedge clk);
        #1;
        `CHK("irq", 1'b1, irq_q)
        wr(`WDRC_OFF_IRQ_STAT, 8'h02);
        @(posedge clk);
        #1;
        `CHK("irq", 1'b0, irq_q)
        rd(`WDRC_OFF_IRQ_STAT, 8'h0C);
        wr(`WDRC_OFF_CAUSE, 8'h1F);
        rd(`WDRC_OFF_CAUSE, 8'h17);
        wr(`WDRC_OFF_CAUSE, 8'h00);
        rd(`WDRC_OFF_CAUSE, 8'h00);
        $display("test cause done");
    endtask
    task automatic t_dog;
        for (int s = 0; s < 8; s++) begin
            n_pulse = 0;
            wr(`WDRC_OFF_CTRL, {5'h01, s[2:0]});
            ticks((BASE << s) - 1);
            `CHK("early", 0, n_pulse)
            ticks(1);
            `CHK("pulse", 1, n_pulse)
            `CHK("active", 1'b0, watchdog_active)
            rd(`WDRC_OFF_CAUSE, 8'h08);
            wr(`WDRC_OFF_CAUSE, 8'h00);
        end
        $display("test timeout done");
    endtask
    task automatic t_restart;
        n_pulse = 0;
        wr(`WDRC_OFF_CTRL, 8'h08);
        ticks(BASE - 1);
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        ticks(BASE - 1);
        `CHK("restart", 0, n_pulse)
        ticks(1);
        `CHK("pulse", 1, n_pulse)
        wr(`WDRC_OFF_CAUSE, 8'h00);
        $display("test restart done");
    endtask
    task automatic t_lock;
        n_pulse = 0;
        wr(`WDRC_OFF_CTRL, 8'h08);
        ticks(BASE - 1);
        wr(`WDRC_OFF_CTRL, 8'h00);
        `CHK("active", 1'b1, watchdog_active)
        wr(`WDRC_OFF_CTRL, 8'h18);
        rd(`WDRC_OFF_CTRL, 8'h18);
        wr(`WDRC_OFF_CTRL, 8'h00);
        `CHK("active", 1'b0, watchdog_active)
        rd(`WDRC_OFF_CTRL, 8'h00);
        wr(`WDRC_OFF_CTRL, 8'h08);
        ticks(BASE - 1);
        `CHK("cleared", 0, n_pulse)
        wr(`WDRC_OFF_CTRL, 8'h18);
        repeat (6) @(posedge clk);
        wr(`WDRC_OFF_CTRL, 8'h00);
        `CHK("active", 1'b1, watchdog_active)
        wr(`WDRC_OFF_CTRL, 8'h18);
        wr(`WDRC_OFF_CTRL, 8'h00);
        ticks(BASE + 2);
        `CHK("idle", 0, n_pulse)
        $display("test lock done");
    endtask
    // a mid-run power-on reset records bit 0 and clears all else
    task automatic t_por;
        src <= 3'h1;
        repeat (8) @(posedge clk);
        src <= 3'h0;
        repeat (8) @(posedge clk);
        rd(`WDRC_OFF_CAUSE, 8'h02);
        `CHK("irq", 1'b1, irq_q)
        reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        rd(`WDRC_OFF_CAUSE, 8'h01);
        rd(`WDRC_OFF_IRQ_STAT, 8'h00);
        rd(`WDRC_OFF_IRQ_MASK, 8'h00);
        `CHK("irq", 1'b0, irq_q)
        $display("test power-on done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        t_reset;
        t_cause;
        t_dog;
        t_restart;
        t_lock;
        t_por;
        give_verdict;
    end
    // tests need about 10000 cycles; three times that means a hang
    initial begin
        #(5 * 30000);
        n_mismatch++;
        give_verdict;
    end
endmodule // watchdog_and_reset_cause_test
